// ===== sar_adc_defs.svh
// register offsets, field positions and timing counts for the converter block
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH

// byte addresses on the 8-bit cpu bus (upper byte at even address)
`define RES_A_HI_ADDR 4'h0
`define RES_A_LO_ADDR 4'h1
`define RES_B_HI_ADDR 4'h2
`define RES_B_LO_ADDR 4'h3
`define RES_C_HI_ADDR 4'h4
`define RES_C_LO_ADDR 4'h5
`define RES_D_HI_ADDR 4'h6
`define RES_D_LO_ADDR 4'h7
`define CTRL_STATUS_ADDR 4'h8
`define TRIG_CTRL_ADDR 4'h9

// converter_control_status fields
`define CS_END_FLAG 7
`define CS_IRQ_EN 6
`define CS_START 5
`define CS_SCAN 4
`define CS_TIME_SEL 3
`define CS_CH_MSB 2
// converter_trigger_control fields
`define TC_TRIG_EN 7
`define TC_RSV_ONES 6'h3F

`define RESULT_BITS 10
`define RESULT_PAD 6'h00
`define MSB_TRIAL 10'h200

// timing: states at the reference rate, mapped to this clock
`define CLK_MHZ 25
`define REF_MHZ 20
`define STATES_SLOW 134
`define STATES_FAST 70
`define T_SLOW_NS (`STATES_SLOW * 1000 / `REF_MHZ)
`define T_FAST_NS (`STATES_FAST * 1000 / `REF_MHZ)
// slow is a longest time (round down), fast is a least time (round up)
`define CYC_SLOW (`T_SLOW_NS * `CLK_MHZ / 1000)
`define CYC_FAST ((`T_FAST_NS * `CLK_MHZ + 999) / 1000)
`define SAMPLE_MIN_CYC 8
`define BIT_CYC_SLOW ((`CYC_SLOW - `SAMPLE_MIN_CYC) / `RESULT_BITS)
`define BIT_CYC_FAST ((`CYC_FAST - `SAMPLE_MIN_CYC) / `RESULT_BITS)
`define SAMP_CYC_SLOW (`CYC_SLOW - `RESULT_BITS * `BIT_CYC_SLOW)
`define SAMP_CYC_FAST (`CYC_FAST - `RESULT_BITS * `BIT_CYC_FAST)

`endif

// ===== sar_adc_pkg.sv
// types for the converter block
`default_nettype none
package sar_adc_pkg;
    typedef enum logic [1:0] {IDLE, SAMPLE, BITS} conv_state_t;

    typedef struct packed {
        logic [3:0][9:0] result;
        logic [7:0] temp_lo;
        logic [15:0] rdata;
        logic end_flag;
        logic irq_en;
        logic start;
        logic scan;
        logic time_sel;
        logic [2:0] chan;
        logic trig_en;
        logic trig_rsv0;
        logic clear_armed;
        conv_state_t fsm;
        logic [7:0] cnt;
        logic [3:0] bit_idx;
        logic [9:0] code;
        logic [2:0] cur_ch;
        logic [2:0] trig_sync;
        logic trig_val;
        logic [2:0] comp_sync;
        logic comp_val;
    } adc_state_t;
endpackage : sar_adc_pkg
`default_nettype wire

// ===== sar_adc_control_results.sv
// control, sequencing and result registers of the 8-channel 10-bit sar converter
//
// Contract
// [RULE_01] convert each selected input by successive approximation into a 10-bit result
// [RULE_02] one channel never converts faster than 3.5 us
// [RULE_03] inputs 0..3 are group 0, inputs 4..7 are group 1
// [RULE_04] single mode converts one selected channel once
// [RULE_05] scan mode converts one to four channels repeatedly in sequence
// [RULE_06] start by software write or by an edge on the trigger pin
// [RULE_07] four 16-bit read-only result registers; writes change nothing
// [RULE_08] inputs 0/4, 1/5, 2/6, 3/7 store to results a, b, c, d
// [RULE_09] result sits left-justified in bits 15..6
// [RULE_10] the six low result bits always read zero
// [RULE_11] upper byte read directly, lower byte via latch; word reads allowed
// [RULE_12] reading an upper byte copies that register's lower byte to the latch
// [RULE_13] software reads upper byte before lower byte
// [RULE_14] reset clears all four results to zero
// [RULE_15] single mode sets the end flag (bit 7) on completion
// [RULE_16] scan mode sets the end flag after each full pass
// [RULE_17] end flag clears only by writing 0 after reading it as 1
// [RULE_18] interrupt request while end flag and enable bit 6 are both set
// [RULE_19] start bit 5 begins; single self-clears; scan runs until cleared
// [RULE_20] bit 4 selects single (0) or scan (1) mode
// [RULE_21] channel field picks one input, or in scan the group's first n inputs
// [RULE_22] time select gives 134 states when 0, 70 states when 1
// [RULE_23] writing 1 to the end flag does nothing
`include "sar_adc_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module sar_adc_control_results (
    // clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic SYS_RST_IN,
    // 8-bit cpu bus
    input wire logic [3:0] BUS_ADDR_IN,
    input wire logic BUS_RD_IN,
    input wire logic BUS_WR_IN,
    input wire logic BUS_WORD_IN,
    input wire logic [7:0] BUS_WDATA_IN,
    output logic [15:0] BUS_RDATA_OUT,
    // trigger and system
    input wire logic EXT_TRIGGER_IN,
    input wire logic TRIG_RISE_IN,
    input wire logic STANDBY_IN,
    // analog front end
    input wire logic COMP_IN,
    output logic SAMPLE_OUT,
    output logic [9:0] DAC_CODE_OUT,
    output logic [2:0] CHANNEL_OUT,
    // status
    output logic BUSY_OUT,
    output logic CONVERSION_END_IRQ_OUT
);

    sar_adc_pkg::adc_state_t s_q;
    sar_adc_pkg::adc_state_t s_d;

    // phase lengths in system clocks
    localparam logic [7:0] SAMP_SLOW = 8'(`SAMP_CYC_SLOW);
    localparam logic [7:0] SAMP_FAST = 8'(`SAMP_CYC_FAST);
    localparam logic [7:0] BIT_SLOW = 8'(`BIT_CYC_SLOW);
    localparam logic [7:0] BIT_FAST = 8'(`BIT_CYC_FAST);

    // agreement filter: a new pin level counts once stages two and three match
    function automatic logic agree(input logic [2:0] sync, input logic held);
        agree = (sync[2] == sync[1]) ? sync[2] : held;
    endfunction : agree

    // byte addresses 0..7 are the result registers, upper byte at the even one
    function automatic logic is_result(input logic [3:0] a);
        is_result = (a[3] == 1'b0);
    endfunction : is_result

    function automatic logic is_status(input logic [3:0] a);
        is_status = (a == `CTRL_STATUS_ADDR);
    endfunction : is_status

    function automatic logic is_trig_ctrl(input logic [3:0] a);
        is_trig_ctrl = (a == `TRIG_CTRL_ADDR);
    endfunction : is_trig_ctrl

    // scan always starts at the first input of the selected group
    function automatic logic [2:0] group_base(input logic [2:0] ch);
        group_base = {ch[2], 2'b00}; // RULE_03
    endfunction : group_base

    // walk the scan set, back to the group's first input after the last one
    function automatic logic [2:0] next_scan_ch(input logic [2:0] cur, input logic [2:0] ch);
        next_scan_ch = (cur[1:0] == ch[1:0]) ? group_base(ch) : cur + 3'h1; // RULE_05
    endfunction : next_scan_ch

    // the sample phase takes what the ten bit periods leave of the total
    function automatic logic [7:0] samp_cycles(input logic ts);
        samp_cycles = ts ? SAMP_FAST : SAMP_SLOW; // RULE_22 RULE_02
    endfunction : samp_cycles

    function automatic logic [7:0] bit_cycles(input logic ts);
        bit_cycles = ts ? BIT_FAST : BIT_SLOW; // RULE_22 RULE_02
    endfunction : bit_cycles

    // one approximation step: keep or drop the trial bit, then try the next one
    function automatic logic [9:0] sar_step(input logic [9:0] c, input logic [3:0] i,
        input logic keep);
        sar_step = c;
        if (!keep) begin
            sar_step[i] = 1'b0; // RULE_01
        end
        if (i != 4'h0) begin
            sar_step[i - 4'h1] = 1'b1; // RULE_01
        end
    endfunction : sar_step

    // status byte as the bus reads it
    function automatic logic [7:0] status_byte(input sar_adc_pkg::adc_state_t s);
        status_byte = {
            s.end_flag,
            s.irq_en,
            s.start,
            s.scan,
            s.time_sel,
            s.chan
        };
    endfunction : status_byte

    // bits six to one have no storage and always read as ones
    function automatic logic [7:0] trig_byte(input sar_adc_pkg::adc_state_t s);
        trig_byte = {
            s.trig_en,
            `TC_RSV_ONES,
            s.trig_rsv0
        };
    endfunction : trig_byte

    // decoded bus strobes and phase ends
    logic [3:0][15:0] res_words;
    logic [15:0] sel_word;
    logic word_rd;
    logic hi_rd;
    logic lo_rd;
    logic status_rd;
    logic trig_rd;
    logic status_wr;
    logic trig_wr;
    logic trig_edge;
    logic samp_done;
    logic bit_done;
    logic pass_end;
    logic [9:0] code_nx;
    logic [2:0] first_ch;

    // one bus view per result register, code left-justified over zero padding
    for (genvar g = 0; g < 4; g++) begin : g_res_word
        assign res_words[g] = {s_q.result[g], `RESULT_PAD}; // RULE_09 RULE_10
    end

    // byte reads of a result: upper byte direct, lower byte from the latch
    assign sel_word = res_words[BUS_ADDR_IN[2:1]];
    assign word_rd = BUS_RD_IN && is_result(BUS_ADDR_IN) && BUS_WORD_IN;
    assign hi_rd = BUS_RD_IN && is_result(BUS_ADDR_IN) && !BUS_WORD_IN && !BUS_ADDR_IN[0];
    assign lo_rd = BUS_RD_IN && is_result(BUS_ADDR_IN) && !BUS_WORD_IN && BUS_ADDR_IN[0];
    assign status_rd = BUS_RD_IN && is_status(BUS_ADDR_IN);
    assign trig_rd = BUS_RD_IN && is_trig_ctrl(BUS_ADDR_IN);
    // result addresses take no write strobe at all
    assign status_wr = BUS_WR_IN && is_status(BUS_ADDR_IN); // RULE_07
    assign trig_wr = BUS_WR_IN && is_trig_ctrl(BUS_ADDR_IN);
    assign samp_done = (s_q.cnt == samp_cycles(s_q.time_sel) - 8'h01);
    assign bit_done = (s_q.cnt == bit_cycles(s_q.time_sel) - 8'h01);
    assign code_nx = sar_step(s_q.code, s_q.bit_idx, s_q.comp_val);
    // last channel of a pass is the one the channel field names
    assign pass_end = (s_q.cur_ch[1:0] == s_q.chan[1:0]); // RULE_16

    always_comb begin
        s_d = s_q;
        trig_edge = 1'b0;
        first_ch = 3'h0;

        // pin inputs: three stages, then the agreement filter
        s_d.trig_sync = {s_q.trig_sync[1:0], EXT_TRIGGER_IN};
        s_d.trig_val = agree(s_q.trig_sync, s_q.trig_val);
        s_d.comp_sync = {s_q.comp_sync[1:0], COMP_IN};
        s_d.comp_val = agree(s_q.comp_sync, s_q.comp_val);
        // filtered level starts low, so a pin held high at reset reads as a rise
        trig_edge = (s_d.trig_val != s_q.trig_val) && (s_d.trig_val == TRIG_RISE_IN);

        // bus reads: data registered, answered one cycle after the strobe
        if (word_rd) begin
            // a word read leaves the latch alone
            s_d.rdata = sel_word; // RULE_11
        end else if (hi_rd) begin
            s_d.rdata = {8'h00, sel_word[15:8]}; // RULE_11
            s_d.temp_lo = sel_word[7:0]; // RULE_12
        end else if (lo_rd) begin
            // every odd result address returns the one shared latch
            s_d.rdata = {8'h00, s_q.temp_lo}; // RULE_11
        end else if (status_rd) begin
            s_d.rdata = {8'h00, status_byte(s_q)};
            if (s_q.end_flag) begin
                s_d.clear_armed = 1'b1; // RULE_17
            end
        end else if (trig_rd) begin
            s_d.rdata = {8'h00, trig_byte(s_q)};
        end else if (BUS_RD_IN) begin
            // unmapped addresses read as zero
            s_d.rdata = 16'h0000;
        end

        // bus writes; result registers ignore writes
        if (status_wr) begin // RULE_07
            if (s_q.clear_armed && !BUS_WDATA_IN[`CS_END_FLAG]) begin
                s_d.end_flag = 1'b0; // RULE_17 RULE_23
            end
            // any status write disarms, so a stale read cannot clear a later flag
            s_d.clear_armed = 1'b0;
            s_d.irq_en = BUS_WDATA_IN[`CS_IRQ_EN];
            s_d.start = BUS_WDATA_IN[`CS_START]; // RULE_06 RULE_19
            s_d.scan = BUS_WDATA_IN[`CS_SCAN]; // RULE_20
            s_d.time_sel = BUS_WDATA_IN[`CS_TIME_SEL];
            s_d.chan = BUS_WDATA_IN[`CS_CH_MSB:0];
        end else if (trig_wr) begin
            s_d.trig_en = BUS_WDATA_IN[`TC_TRIG_EN];
            s_d.trig_rsv0 = BUS_WDATA_IN[0];
        end
        if (trig_edge && s_q.trig_en) begin
            s_d.start = 1'b1; // RULE_06
        end
        if (STANDBY_IN) begin
            s_d.start = 1'b0; // RULE_19
        end

        first_ch = s_d.scan ? group_base(s_d.chan) : s_d.chan; // RULE_03 RULE_21

        unique case (s_q.fsm)
            sar_adc_pkg::IDLE: begin
                if (s_d.start) begin
                    s_d.fsm = sar_adc_pkg::SAMPLE;
                    s_d.cnt = 8'h00;
                    s_d.cur_ch = first_ch; // RULE_04 RULE_21
                end
            end
            sar_adc_pkg::SAMPLE: begin
                s_d.cnt = s_q.cnt + 8'h01;
                if (samp_done) begin
                    s_d.fsm = sar_adc_pkg::BITS;
                    s_d.cnt = 8'h00;
                    s_d.bit_idx = 4'h9;
                    s_d.code = `MSB_TRIAL;
                end
            end
            sar_adc_pkg::BITS: begin
                s_d.cnt = s_q.cnt + 8'h01;
                if (bit_done) begin
                    s_d.cnt = 8'h00;
                    // decision uses the filtered comparator, a few cycles behind the code
                    s_d.code = code_nx; // RULE_01
                    if (s_q.bit_idx == 4'h0) begin
                        s_d.result[s_q.cur_ch[1:0]] = code_nx; // RULE_08
                        if (!s_q.scan) begin
                            s_d.start = 1'b0; // RULE_19 RULE_04
                            // a hardware set wins over a clear in the same cycle
                            s_d.end_flag = 1'b1; // RULE_15
                            s_d.fsm = sar_adc_pkg::IDLE;
                        end else begin
                            s_d.fsm = sar_adc_pkg::SAMPLE; // RULE_05
                            s_d.cur_ch = next_scan_ch(s_q.cur_ch, s_q.chan);
                            if (pass_end) begin
                                s_d.end_flag = 1'b1; // RULE_16
                            end
                        end
                    end else begin
                        s_d.bit_idx = s_q.bit_idx - 4'h1;
                    end
                end
            end
        endcase
        // start cleared by software or standby stops the sequence at once
        if (s_q.fsm != sar_adc_pkg::IDLE && !s_d.start) begin // RULE_19
            s_d.fsm = sar_adc_pkg::IDLE;
            s_d.code = 10'h000;
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            s_q <= '0; // RULE_14
        end else begin
            s_q <= s_d;
        end
    end

    assign BUS_RDATA_OUT = s_q.rdata;
    assign SAMPLE_OUT = (s_q.fsm == sar_adc_pkg::SAMPLE);
    assign DAC_CODE_OUT = s_q.code;
    assign CHANNEL_OUT = s_q.cur_ch;
    assign BUSY_OUT = (s_q.fsm != sar_adc_pkg::IDLE);
    assign CONVERSION_END_IRQ_OUT = s_q.end_flag & s_q.irq_en; // RULE_18

endmodule : sar_adc_control_results
`default_nettype wire

// ===== analog_front_model.sv
// comparator model of the analog inputs facing the converter
`timescale 1ns/1ns
`default_nettype none
module analog_front_model (
    // levels and selection
    input wire logic [7:0][9:0] level_in,
    input wire logic [2:0] channel_in,
    input wire logic [9:0] code_in,
    // decision
    output logic comp_out
);
    // ideal comparator; the block filters it, so a short settle delay is harmless
    assign #3 comp_out = level_in[channel_in] >= code_in;
endmodule : analog_front_model
`default_nettype wire

// ===== sar_adc_control_results_sva.sv
// assertions on the ports of the converter block
`timescale 1ns/1ns
`default_nettype none
module sar_adc_checker (
    input wire logic CLK_SYS_IN,
    input wire logic SYS_RST_IN,
    input wire logic [3:0] BUS_ADDR_IN,
    input wire logic BUS_RD_IN,
    input wire logic BUS_WR_IN,
    input wire logic BUS_WORD_IN,
    input wire logic STANDBY_IN,
    input wire logic [15:0] BUS_RDATA_OUT,
    input wire logic SAMPLE_OUT,
    input wire logic [2:0] CHANNEL_OUT,
    input wire logic BUSY_OUT,
    input wire logic CONVERSION_END_IRQ_OUT
);
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (SYS_RST_IN);
    logic [7:0] since_q;
    // saturating count of busy cycles, lower bound only
    always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) since_q <= 8'h00;
        else if (!BUSY_OUT) since_q <= 8'h00;
        else if (since_q != 8'hFF) since_q <= since_q + 8'h01;
    end
    sequence s_sample8;
        // a cleared start may end the phase early, leaving the block idle
        (SAMPLE_OUT || !BUSY_OUT) [*8];
    endsequence
    sample_len_a: assert property ($rose(SAMPLE_OUT) |-> s_sample8)
        else $error("sample phase short");
    busy_sample_a: assert property ($rose(BUSY_OUT) |-> SAMPLE_OUT)
        else $error("no sample first");
    conv_time_a: assert property ($rose(CONVERSION_END_IRQ_OUT) && !$past(BUS_WR_IN)
        |-> since_q >= 8'd80) else $error("conversion too fast");
    word_pad_a: assert property (BUS_RD_IN && BUS_WORD_IN && BUS_ADDR_IN < 4'h8
        |=> BUS_RDATA_OUT[5:0] == 6'h00) else $error("word low bits set");
    byte_hi_a: assert property (BUS_RD_IN && !BUS_WORD_IN |=> BUS_RDATA_OUT[15:8] == 8'h00)
        else $error("byte read upper set");
    lo_pad_a: assert property (BUS_RD_IN && !BUS_WORD_IN && BUS_ADDR_IN < 4'h8 && BUS_ADDR_IN[0]
        |=> BUS_RDATA_OUT[5:0] == 6'h00) else $error("low byte pad set");
    rdata_hold_a: assert property (!BUS_RD_IN |=> $stable(BUS_RDATA_OUT))
        else $error("read data moved");
    unmapped_a: assert property (BUS_RD_IN && BUS_ADDR_IN >= 4'hA |=> BUS_RDATA_OUT == 16'h0000)
        else $error("unmapped read nonzero");
    standby_stop_a: assert property (STANDBY_IN |-> ##[1:3] !BUSY_OUT)
        else $error("standby did not stop");
    chan_hold_a: assert property (BUSY_OUT && !SAMPLE_OUT
        |=> !BUSY_OUT || SAMPLE_OUT || $stable(CHANNEL_OUT)) else $error("channel moved");
    irq_cause_a: assert property ($rose(CONVERSION_END_IRQ_OUT)
        |-> $past(BUSY_OUT) || $past(BUS_WR_IN)) else $error("irq without cause");
endmodule : sar_adc_checker
bind sar_adc_control_results sar_adc_checker sar_adc_checker_i (.CLK_SYS_IN(CLK_SYS_IN),
    .SYS_RST_IN(SYS_RST_IN), .BUS_ADDR_IN(BUS_ADDR_IN), .BUS_RD_IN(BUS_RD_IN),
    .BUS_WR_IN(BUS_WR_IN), .BUS_WORD_IN(BUS_WORD_IN), .STANDBY_IN(STANDBY_IN),
    .BUS_RDATA_OUT(BUS_RDATA_OUT), .SAMPLE_OUT(SAMPLE_OUT), .CHANNEL_OUT(CHANNEL_OUT),
    .BUSY_OUT(BUSY_OUT), .CONVERSION_END_IRQ_OUT(CONVERSION_END_IRQ_OUT));
`default_nettype wire

// ===== tb.sv
// self-checking bench for the converter control and result block
`include "sar_adc_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, word = 1'b0;
    logic trig = 1'b0, rise = 1'b1, stby = 1'b0, comp, sample, busy, irq;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [15:0] rdata, d, h;
    logic [9:0] dac;
    logic [2:0] chan;
    logic [7:0][9:0] lvl;
    int fail_count = 0, cmp_count = 0, n;
    sar_adc_control_results sar_adc_control_results_i (.CLK_SYS_IN(clk), .SYS_RST_IN(rst),
        .BUS_ADDR_IN(addr), .BUS_RD_IN(rd), .BUS_WR_IN(wr), .BUS_WORD_IN(word),
        .BUS_WDATA_IN(wdata), .BUS_RDATA_OUT(rdata), .EXT_TRIGGER_IN(trig),
        .TRIG_RISE_IN(rise), .STANDBY_IN(stby), .COMP_IN(comp), .SAMPLE_OUT(sample),
        .DAC_CODE_OUT(dac), .CHANNEL_OUT(chan), .BUSY_OUT(busy), .CONVERSION_END_IRQ_OUT(irq));
    analog_front_model analog_front_model_i (.level_in(lvl), .channel_in(chan),
        .code_in(dac), .comp_out(comp));
    initial begin
        forever #20 clk = ~clk;
    end
    function automatic logic [15:0] res(input logic [9:0] v);
        return {v, 6'h00};
    endfunction : res
    function automatic int cyc(input logic ts);
        return ts ? `CYC_FAST : `CYC_SLOW;
    endfunction : cyc
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    // one strobe cycle; read data is taken just after the answering edge
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v, input logic wd);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= v;
        word <= wd;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        word <= 1'b0;
        #1 d = rdata;
    endtask : acc
    task automatic wait_irq(input int lim);
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= lim) begin
            fail_count++;
            end_of_test();
        end
    endtask : wait_irq
    initial begin
        void'($urandom(53060));
        for (int i = 0; i < 8; i++) lvl[i] = 10'($urandom);
        lvl[0] = 10'h000;
        lvl[7] = 10'h3FF;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            acc(0, 4'(2 * k), 8'h00, 1);
            chk("reset result", d, 16'h0000);
        end
        acc(0, 4'h9, 8'h00, 0);
        chk("trigger ctrl", d, 16'h007E);
        acc(0, 4'hB, 8'h00, 0);
        chk("unmapped", d, 16'h0000);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            acc(1, 4'h8, {4'b0110, c[0], 3'(c)}, 0);
            wait_irq(400);
            chk("conv time", 16'(n >= cyc(c[0]) && n <= cyc(c[0]) + 4), 16'h0001);
            acc(1, 4'(2 * (c % 4)), 8'hFF, 0);
            acc(0, 4'(2 * (c % 4)), 8'h00, 1);
            chk("word result", d, res(lvl[c]));
            acc(0, 4'(2 * (c % 4)), 8'h00, 0);
            h = d;
            acc(0, 4'(2 * (c % 4) + 1), 8'h00, 0);
            chk("byte result", {h[7:0], d[7:0]}, res(lvl[c]));
            acc(1, 4'h8, 8'h40, 0);
            chk("flag kept", 16'(irq), 16'h0001);
            acc(0, 4'h8, 8'h00, 0);
            chk("single status", d, 16'h00C0);
            acc(1, 4'h8, 8'h40, 0);
            chk("flag clear", 16'(irq), 16'h0000);
            acc(1, 4'h8, 8'hC0, 0);
            chk("flag write one", 16'(irq), 16'h0000);
        end
        $display("test single done");
        for (int k = 4; k < 8; k++) lvl[k] <= 10'($urandom);
        acc(1, 4'h8, 8'h7E, 0);
        wait_irq(1200);
        for (int k = 0; k < 4; k++) begin
            acc(0, 4'(2 * k), 8'h00, 1);
            chk("scan result", d, k < 3 ? res(lvl[4 + k]) : res(10'h3FF));
        end
        acc(0, 4'h8, 8'h00, 0);
        chk("scan status", d, 16'h00FE);
        acc(1, 4'h8, 8'h7E, 0);
        chk("scan clear", 16'(irq), 16'h0000);
        wait_irq(1200);
        acc(0, 4'h8, 8'h00, 0);
        acc(1, 4'h8, 8'h00, 0);
        repeat (3) @(posedge clk);
        #1 chk("scan stop", 16'({busy, irq}), 16'h0000);
        $display("test scan done");
        lvl[2] <= 10'($urandom);
        acc(1, 4'h9, 8'h80, 0);
        acc(1, 4'h8, 8'h42, 0);
        @(posedge clk);
        trig <= 1'b1;
        wait_irq(400);
        acc(0, 4'h4, 8'h00, 1);
        chk("trigger result", d, res(lvl[2]));
        acc(0, 4'h8, 8'h00, 0);
        acc(1, 4'h8, 8'h00, 0);
        $display("test trigger done");
        acc(1, 4'h8, 8'h20, 0);
        repeat (40) @(posedge clk);
        stby <= 1'b1;
        @(posedge clk);
        stby <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("standby busy", 16'(busy), 16'h0000);
        acc(0, 4'h8, 8'h00, 0);
        chk("standby status", d, 16'h0000);
        acc(0, 4'h0, 8'h00, 1);
        chk("abort result", d, res(lvl[4]));
        $display("test standby done");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
